// >>> common/nds_pkg.sv
// package: nanoword layout, decode codes and reset values of the sequencer
package nds_pkg;

  localparam int DATA_W = 16;
  localparam int ADDR_W = 12;
  localparam int BASE_W = 8;
  localparam int SAR_W = 4;
  localparam int REQ_W = 4;

  ////////////////////////////////////////////////////////////////////////////
  // nanoword, bit 55 down to bit 1
  typedef struct packed {
    logic ssc_ld;        // bit 55
    logic [3:0] req;     // bits 54-51
    logic [1:0] sar_sel; // bits 50-49
    logic [1:0] ctr_hi;  // bits 48-47
    logic [1:0] mar_sel; // bits 46-45, memory address register source select
    logic br2_ld;        // bit 44
    logic br1_ld;        // bit 43
    logic alt_ld;        // bit 42
    logic mir_ld;        // bit 41
    logic [3:0] b_sel;   // bits 40-37
    logic [2:0] a_sel;   // bits 36-34
    logic [1:0] shift;   // bits 33-32
    logic [3:0] op;      // bits 31-28
    logic no_carry;      // bit 27
    logic [6:0] y_sel;   // bits 26-20
    logic [2:0] x_sel;   // bits 19-17
    logic [5:0] succ;    // bits 16-11, false successor high, true low
    logic [2:0] adj;     // bits 10-8
    logic ext_gate;      // bit 7
    logic lu_gate;       // bit 6
    logic sense;         // bit 5
    logic [3:0] cond;    // bits 4-1
  } nds_nano_t;

  ////////////////////////////////////////////////////////////////////////////
  // decode codes
  localparam logic [3:0] COND_TRUE = 4'h0, COND_AOV = 4'h1, COND_ABT = 4'h2, COND_COV = 4'h3;
  localparam logic [3:0] COND_LC1 = 4'h4, COND_LC2 = 4'h5, COND_LC3 = 4'h6, COND_EXT = 4'h7;
  localparam logic [3:0] COND_LSB = 4'h8;
  localparam logic [2:0] SUCC_STEP = 3'h0, SUCC_SKIP = 3'h1, SUCC_CALL = 3'h2, SUCC_EXEC = 3'h3;
  localparam logic [2:0] SUCC_JUMP = 3'h4, SUCC_WAIT = 3'h5, SUCC_SAVE = 3'h6, SUCC_RETN = 3'h7;
  localparam logic [2:0] ADJ_NONE = 3'h0, ADJ_LC1 = 3'h1, ADJ_LC2 = 3'h2, ADJ_LC3 = 3'h3;
  localparam logic [2:0] ADJ_SEL2 = 3'h4, ADJ_STATREQ = 3'h5;
  localparam logic [2:0] X_A1 = 3'h0, X_A2 = 3'h1, X_A3 = 3'h2, X_LIT = 3'h3;
  localparam logic [2:0] Y_B = 3'h0, Y_MIR = 3'h1, Y_ALT = 3'h2, Y_LIT = 3'h3;
  localparam logic [2:0] Y_BCAT = 3'h4, Y_CTR = 3'h5, Y_SAR = 3'h6;
  localparam int Y_COMP_BIT = 3;
  localparam logic [3:0] OP_ADD = 4'h0, OP_SUB = 4'h1, OP_AND = 4'h2, OP_OR = 4'h3;
  localparam logic [3:0] OP_XOR = 4'h4, OP_AAD = 4'h5, OP_EQV = 4'h6, OP_IMP = 4'h7;
  localparam logic [3:0] OP_PASSX = 4'h8, OP_PASSY = 4'h9;
  localparam logic [1:0] SH_NONE = 2'h0, SH_RIGHT = 2'h1, SH_LEFT = 2'h2, SH_CIRC = 2'h3;
  localparam logic [2:0] A_ONE = 3'h1, A_TWO = 3'h2, A_THREE = 3'h3;
  localparam logic [3:0] B_BSW = 4'h1, B_ADD = 4'h2, B_ADD_BSW = 4'h3, B_EXT = 4'h4;
  localparam logic [3:0] B_EXT_BSW = 4'h5, B_MIR = 4'h6, B_MIR_BSW = 4'h7, B_NC4 = 4'h8;
  localparam logic [3:0] B_NC8 = 4'h9;
  localparam logic [1:0] MAR_BSW = 2'h1, MAR_LIT = 2'h2;
  localparam logic [1:0] CTR_LIT = 2'h1, CTR_BSW = 2'h2, CTR_INC = 2'h3;
  localparam logic [1:0] SAR_BSW = 2'h1, SAR_COMP = 2'h2;
  localparam logic [2:0] LD_SAR = 3'h0, LD_LIT = 3'h1, LD_BOTH = 3'h2, LD_ALT = 3'h3;
  localparam logic [2:0] LD_CALLMARK = 3'h4, LD_MARK = 3'h5;

  // reset values
  localparam logic [ADDR_W-1:0] RESET_ADDR = 12'h000;
  localparam logic [DATA_W-1:0] RESET_WORD = 16'h0000;

  typedef enum logic {P3_RUN, P3_EXTEND} nds_p3_t;

endpackage

// >>> common/nds_alu_if.sv
// interface: operands, function and results between sequencer and adder
`timescale 1ns/10ps
interface nds_alu_if;
  logic [15:0] x;
  logic [15:0] y;
  logic [3:0] op;
  logic no_carry;
  logic [15:0] sum;
  logic c4;
  logic c8;
  logic ovf;
  modport host (output x, output y, output op, output no_carry,
                input sum, input c4, input c8, input ovf);
  modport unit (input x, input y, input op, input no_carry,
                output sum, output c4, output c8, output ovf);
endinterface

// >>> hdl/nds_adder.sv
// module: nibble-sliced adder and logic unit with byte carry inhibit
`timescale 1ns/10ps
module nds_adder (
  nds_alu_if.unit alu
);
  logic [15:0] opa;
  logic [15:0] opb;
  logic cin;
  logic [4:0] carry;
  logic [15:0] asum;

  // operand shaping per function
  always_comb begin
    opa = alu.x;
    opb = alu.y;
    cin = 1'b0;
    if (alu.op == nds_pkg::OP_SUB) begin
      opb = ~alu.y;
      cin = 1'b1;
    end else if (alu.op == nds_pkg::OP_AAD) begin
      opb = alu.x & alu.y; // x plus (x and y)
    end
  end

  // carry chain by nibble; byte boundary may take the fresh carry-in
  assign carry[0] = cin;
  for (genvar g = 0; g < 4; g++) begin : g_nib
    logic ci;
    assign ci = (g == 2 && alu.no_carry) ? cin : carry[g];
    assign {carry[g+1], asum[4*g+3:4*g]} = {1'b0, opa[4*g+3:4*g]} + {1'b0, opb[4*g+3:4*g]}
                                         + {4'h0, ci};
  end

  // result select and dynamic conditions
  always_comb begin
    case (alu.op)
      nds_pkg::OP_AND: alu.sum = alu.x & alu.y;
      nds_pkg::OP_OR: alu.sum = alu.x | alu.y;
      nds_pkg::OP_XOR: alu.sum = alu.x ^ alu.y;
      nds_pkg::OP_EQV: alu.sum = ~(alu.x ^ alu.y);
      nds_pkg::OP_IMP: alu.sum = ~alu.x | alu.y;
      nds_pkg::OP_PASSX: alu.sum = alu.x;
      nds_pkg::OP_PASSY: alu.sum = alu.y;
      default: alu.sum = asum;
    endcase
    alu.c4 = carry[1];
    alu.c8 = carry[2];
    alu.ovf = (opa[15] == opb[15]) && (asum[15] != opa[15]);
  end
endmodule // nds_adder

// >>> hdl/nds_sequencer.sv
// module: nanoword decode and phase 1 / phase 3 sequencer with its registers
`timescale 1ns/10ps
module nds_sequencer (
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic I_CE,
  input wire logic I_LIT_WORD,
  input wire logic [2:0] I_LIT_DEST,
  input wire logic [15:0] I_LIT_VALUE,
  input wire logic [55:1] I_NANO_WORD,
  input wire logic [15:0] I_EXT_BUS,
  input wire logic [3:0] I_DEV_PEND,
  input wire logic [3:0] I_DEV_SEL,
  output logic [11:0] O_FETCH_ADDR,
  output logic [11:0] O_MICRO_PC,
  output logic [11:0] O_STEP_VALUE,
  output logic O_EXT3,
  output logic [2:0] O_COND_ADJ,
  output logic [3:0] O_MEM_DEV_REQ,
  output logic O_STATUS_REQ,
  output logic [1:0] O_STATUS_DEV,
  output logic [7:0] O_MAR,
  output logic [15:0] O_MIR,
  output logic [15:0] O_ACC_ONE,
  output logic [15:0] O_B_REG
);

  typedef struct packed {
    nds_pkg::nds_nano_t p3;
    nds_pkg::nds_p3_t p3_state;
    logic [11:0] fetch;
    logic [11:0] mpc;
    logic [11:0] alt;
    logic [11:0] step;
    logic [15:0] a1;
    logic [15:0] a2;
    logic [15:0] a3;
    logic [15:0] b;
    logic [15:0] memory_info_reg;
    logic [15:0] ctr;
    logic [15:0] constant_field_reg;
    logic [7:0] br1;
    logic [7:0] br2;
    logic [7:0] memory_address_reg;
    logic [3:0] shift_amount_reg;
    logic sign_save_control;
    logic adder_overflow_flag;
    logic adder_all_ones_flag;
    logic lst;
    logic cov;
    logic [2:0] lc;
    logic base_two;
    logic [3:0] req;
    logic [2:0] adj;
    logic stat_req;
    logic [1:0] stat_dev;
    logic [15:0] ext_s1;
    logic [15:0] ext_s2;
    logic [3:0] pend_s1;
    logic [3:0] pend_s2;
    logic [3:0] sel_s1;
    logic [3:0] sel_s2;
  } nds_seq_t;

  nds_seq_t st;
  nds_seq_t next_st;
  nds_pkg::nds_nano_t n;
  nds_pkg::nds_nano_t p;
  nds_alu_if alu ();
  logic raw;
  logic met;
  logic logic_unit_phase_request;
  logic external_action_request;
  logic [2:0] succ;
  logic [15:0] bcat;
  logic [15:0] ysrc;
  logic [15:0] barrel_shifter;
  logic [3:0] avail;
  logic [1:0] free_dev;
  logic [11:0] lit_next;
  logic [16:0] ctr_inc;

  nds_adder u_adder (
    .alu(alu)
  );

  assign n = nds_pkg::nds_nano_t'(I_NANO_WORD);
  assign p = st.p3;

  ////////////////////////////////////////////////////////////////////////////
  // phase 1: condition test and gating
  always_comb begin
    case (n.cond)
      nds_pkg::COND_TRUE: raw = 1'b1;
      nds_pkg::COND_AOV: raw = st.adder_overflow_flag;
      nds_pkg::COND_ABT: raw = st.adder_all_ones_flag;
      nds_pkg::COND_COV: raw = st.cov;
      nds_pkg::COND_LC1: raw = st.lc[0];
      nds_pkg::COND_LC2: raw = st.lc[1];
      nds_pkg::COND_LC3: raw = st.lc[2];
      nds_pkg::COND_EXT: raw = |st.ext_s2;
      nds_pkg::COND_LSB: raw = st.lst;
      default: raw = 1'b0;
    endcase
    met = n.sense ? raw : ~raw;
    logic_unit_phase_request = ~I_LIT_WORD & (~n.lu_gate | met);
    external_action_request = ~I_LIT_WORD & (~n.ext_gate | met);
    succ = met ? n.succ[2:0] : n.succ[5:3];
  end

  ////////////////////////////////////////////////////////////////////////////
  // phase 3: operand select, adder drive and barrel shifter
  always_comb begin
    bcat = st.base_two ? {st.br2, st.memory_address_reg} : {st.br1, st.memory_address_reg};
    case (p.x_sel)
      nds_pkg::X_A1: alu.x = st.a1;
      nds_pkg::X_A2: alu.x = st.a2;
      nds_pkg::X_A3: alu.x = st.a3;
      nds_pkg::X_LIT: alu.x = st.constant_field_reg;
      default: alu.x = nds_pkg::RESET_WORD;
    endcase
    case (p.y_sel[2:0])
      nds_pkg::Y_B: ysrc = st.b;
      nds_pkg::Y_MIR: ysrc = st.memory_info_reg;
      nds_pkg::Y_ALT: ysrc = {4'h0, st.alt};
      nds_pkg::Y_LIT: ysrc = st.constant_field_reg;
      nds_pkg::Y_BCAT: ysrc = bcat;
      nds_pkg::Y_CTR: ysrc = st.ctr;
      nds_pkg::Y_SAR: ysrc = {12'h000, st.shift_amount_reg};
      default: ysrc = nds_pkg::RESET_WORD;
    endcase
    alu.y = p.y_sel[nds_pkg::Y_COMP_BIT] ? ~ysrc : ysrc;
    alu.op = p.op;
    alu.no_carry = p.no_carry;
    case (p.shift)
      nds_pkg::SH_RIGHT: barrel_shifter = alu.sum >> st.shift_amount_reg;
      nds_pkg::SH_LEFT: barrel_shifter = alu.sum << st.shift_amount_reg;
      nds_pkg::SH_CIRC: barrel_shifter = (alu.sum >> st.shift_amount_reg) | (alu.sum << (5'd16 - {1'b0, st.shift_amount_reg}));
      default: barrel_shifter = alu.sum;
    endcase
    ctr_inc = {1'b0, st.ctr} + 17'h00001;
    lit_next = I_LIT_VALUE[11:0] + 12'h001;
  end

  // highest priority pending device not yet selected, index 0 first
  always_comb begin
    avail = st.pend_s2 & ~st.sel_s2;
    if (avail[0]) begin
      free_dev = 2'h0;
    end else if (avail[1]) begin
      free_dev = 2'h1;
    end else if (avail[2]) begin
      free_dev = 2'h2;
    end else begin
      free_dev = 2'h3;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state: one word decoded per clock
  always_comb begin
    next_st = st;
    // pin synchronisers
    next_st.ext_s1 = I_EXT_BUS;
    next_st.ext_s2 = st.ext_s1;
    next_st.pend_s1 = I_DEV_PEND;
    next_st.pend_s2 = st.pend_s1;
    next_st.sel_s1 = I_DEV_SEL;
    next_st.sel_s2 = st.sel_s1;
    // external operation pulses
    next_st.req = external_action_request ? n.req : 4'h0;
    next_st.adj = external_action_request ? n.adj : nds_pkg::ADJ_NONE;
    next_st.stat_req = external_action_request && n.adj == nds_pkg::ADJ_STATREQ && |avail;
    next_st.stat_dev = free_dev;
    // phase 3 completes only when a new one is demanded
    next_st.p3_state = logic_unit_phase_request ? nds_pkg::P3_RUN : nds_pkg::P3_EXTEND;
    // destination writes, all on this one edge
    if (logic_unit_phase_request) begin
      next_st.p3 = n;
      next_st.adder_overflow_flag = alu.ovf;
      next_st.adder_all_ones_flag = &alu.sum;
      next_st.lst = alu.sum[0];
      if (p.ssc_ld) begin
        next_st.sign_save_control = alu.sum[15];
      end
      case (p.a_sel)
        nds_pkg::A_ONE: next_st.a1 = barrel_shifter;
        nds_pkg::A_TWO: next_st.a2 = barrel_shifter;
        nds_pkg::A_THREE: next_st.a3 = barrel_shifter;
        default: ;
      endcase
      case (p.b_sel)
        nds_pkg::B_BSW: next_st.b = barrel_shifter;
        nds_pkg::B_ADD: next_st.b = alu.sum;
        nds_pkg::B_ADD_BSW: next_st.b = alu.sum | barrel_shifter;
        nds_pkg::B_EXT: next_st.b = st.ext_s2;
        nds_pkg::B_EXT_BSW: next_st.b = st.ext_s2 | barrel_shifter;
        nds_pkg::B_MIR: next_st.b = st.memory_info_reg;
        nds_pkg::B_MIR_BSW: next_st.b = st.memory_info_reg | barrel_shifter;
        nds_pkg::B_NC4: next_st.b = {15'h0000, ~alu.c4};
        nds_pkg::B_NC8: next_st.b = {15'h0000, ~alu.c8};
        default: ;
      endcase
      if (p.mir_ld) begin
        next_st.memory_info_reg = barrel_shifter;
      end
      if (p.alt_ld) begin
        next_st.alt = barrel_shifter[11:0];
      end
      if (p.br1_ld) begin
        next_st.br1 = barrel_shifter[7:0];
      end
      if (p.br2_ld) begin
        next_st.br2 = barrel_shifter[7:0];
      end
      if (p.mar_sel == nds_pkg::MAR_BSW) begin
        next_st.memory_address_reg = barrel_shifter[7:0];
      end else if (p.mar_sel == nds_pkg::MAR_LIT) begin
        next_st.memory_address_reg = st.constant_field_reg[7:0];
      end
      case (p.ctr_hi)
        nds_pkg::CTR_LIT: begin
          next_st.ctr = st.constant_field_reg;
          next_st.cov = 1'b0;
        end
        nds_pkg::CTR_BSW: begin
          next_st.ctr = barrel_shifter;
          next_st.cov = 1'b0;
        end
        nds_pkg::CTR_INC: begin
          next_st.ctr = ctr_inc[15:0];
          next_st.cov = st.cov | ctr_inc[16];
        end
        default: ;
      endcase
      if (p.sar_sel == nds_pkg::SAR_BSW) begin
        next_st.shift_amount_reg = barrel_shifter[3:0];
      end else if (p.sar_sel == nds_pkg::SAR_COMP) begin
        next_st.shift_amount_reg = ~st.shift_amount_reg;
      end
    end
    if (I_LIT_WORD) begin
      // literal word: step successor and literal destinations
      next_st.fetch = st.mpc + 12'h001;
      next_st.mpc = st.mpc + 12'h001;
      case (I_LIT_DEST)
        nds_pkg::LD_SAR: next_st.shift_amount_reg = I_LIT_VALUE[3:0];
        nds_pkg::LD_LIT: next_st.constant_field_reg = I_LIT_VALUE;
        nds_pkg::LD_BOTH: begin
          next_st.shift_amount_reg = I_LIT_VALUE[3:0];
          next_st.constant_field_reg = I_LIT_VALUE;
        end
        nds_pkg::LD_ALT: next_st.alt = I_LIT_VALUE[11:0];
        nds_pkg::LD_CALLMARK: begin
          next_st.fetch = lit_next;
          next_st.mpc = lit_next;
          next_st.step = lit_next;
          next_st.alt = st.mpc;
        end
        nds_pkg::LD_MARK: begin
          next_st.fetch = lit_next;
          next_st.mpc = lit_next;
          next_st.step = lit_next;
        end
        default: ;
      endcase
    end else begin
      // successor
      case (succ)
        nds_pkg::SUCC_SKIP: begin
          next_st.fetch = st.mpc + 12'h002;
          next_st.mpc = st.mpc + 12'h002;
        end
        nds_pkg::SUCC_CALL: begin
          next_st.fetch = st.alt + 12'h001;
          next_st.mpc = st.alt + 12'h001;
          next_st.alt = st.mpc;
        end
        nds_pkg::SUCC_EXEC: next_st.fetch = st.alt + 12'h001;
        nds_pkg::SUCC_JUMP, nds_pkg::SUCC_RETN: begin
          next_st.fetch = st.alt + 12'h001;
          next_st.mpc = st.alt + 12'h001;
        end
        nds_pkg::SUCC_WAIT: next_st.fetch = st.mpc;
        nds_pkg::SUCC_SAVE: begin
          next_st.alt = st.mpc;
          next_st.fetch = st.mpc + 12'h001;
          next_st.mpc = st.mpc + 12'h001;
        end
        default: begin
          next_st.fetch = st.mpc + 12'h001;
          next_st.mpc = st.mpc + 12'h001;
        end
      endcase
      // a tested local flag clears; a set in the same word wins
      if (n.cond == nds_pkg::COND_LC1) next_st.lc[0] = 1'b0;
      if (n.cond == nds_pkg::COND_LC2) next_st.lc[1] = 1'b0;
      if (n.cond == nds_pkg::COND_LC3) next_st.lc[2] = 1'b0;
    end
    if (external_action_request) begin
      case (n.adj)
        nds_pkg::ADJ_LC1: next_st.lc[0] = 1'b1;
        nds_pkg::ADJ_LC2: next_st.lc[1] = 1'b1;
        nds_pkg::ADJ_LC3: next_st.lc[2] = 1'b1;
        nds_pkg::ADJ_SEL2: next_st.base_two = 1'b1;
        nds_pkg::ADJ_STATREQ: next_st.base_two = 1'b0;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      st <= '0;
      st.fetch <= nds_pkg::RESET_ADDR;
      st.mpc <= nds_pkg::RESET_ADDR;
      st.p3_state <= nds_pkg::P3_RUN;
    end else if (I_CE) begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  assign O_FETCH_ADDR = st.fetch;
  assign O_MICRO_PC = st.mpc;
  assign O_STEP_VALUE = st.step;
  assign O_EXT3 = (st.p3_state == nds_pkg::P3_EXTEND);
  assign O_COND_ADJ = st.adj;
  assign O_MEM_DEV_REQ = st.req;
  assign O_STATUS_REQ = st.stat_req;
  assign O_STATUS_DEV = st.stat_dev; // registered, one cycle behind the synchronisers
  assign O_MAR = st.memory_address_reg;
  assign O_MIR = st.memory_info_reg;
  assign O_ACC_ONE = st.a1;
  assign O_B_REG = st.b;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);

  sequence s_word;
    I_CE && !I_LIT_WORD;
  endsequence
  sequence s_call;
    s_word ##0 succ == nds_pkg::SUCC_CALL;
  endsequence
  sequence s_jump;
    s_word ##0 succ == nds_pkg::SUCC_JUMP;
  endsequence

  a_ext3_hold: assert property (I_CE && !logic_unit_phase_request |=> O_EXT3 && $stable(st.a1) && $stable(st.b))
    else $error("phase 3 registers changed while extended");
  a_lu_uncond: assert property (s_word ##0 !n.lu_gate |=> !O_EXT3)
    else $error("unconditional logic-unit phase not taken");
  a_ext_gated: assert property (I_CE && !external_action_request |=> O_MEM_DEV_REQ == 4'h0 && O_COND_ADJ == 3'h0)
    else $error("external request issued while gated off");
  a_req_issue: assert property (I_CE && external_action_request |=> O_MEM_DEV_REQ == $past(n.req))
    else $error("request code not issued");
  a_call_swap: assert property (s_call |=> O_FETCH_ADDR == $past(st.alt) + 12'h001
    && st.alt == $past(st.mpc))
    else $error("call did not swap return point");
  a_jump_copy: assert property (s_jump |=> O_MICRO_PC == $past(st.alt) + 12'h001
    && O_FETCH_ADDR == O_MICRO_PC)
    else $error("jump address not copied");
  a_flag_clear: assert property (s_word ##0 n.cond == nds_pkg::COND_LC1
    && !(external_action_request && n.adj == nds_pkg::ADJ_LC1) |=> !st.lc[0])
    else $error("tested local flag not cleared");
  a_acc_load: assert property (I_CE && logic_unit_phase_request && p.a_sel == nds_pkg::A_ONE
    |=> O_ACC_ONE == $past(barrel_shifter))
    else $error("accumulator not loaded from shifter");
  a_mark_call: assert property (I_CE && I_LIT_WORD && I_LIT_DEST == nds_pkg::LD_CALLMARK
    |=> O_MICRO_PC == $past(lit_next) && O_STEP_VALUE == O_MICRO_PC
    && st.alt == $past(st.mpc))
    else $error("call-mark literal word wrong");

endmodule // nds_sequencer

// >>> sim/nds_mpm_model.sv
// microprogram memory model: literal and nanoword entries read at the fetch address
`timescale 1ns/10ps
module nds_mpm_model (
  input wire logic i_clk,
  input wire logic i_wr,
  input wire logic [5:0] i_wr_addr,
  input wire logic [74:0] i_wr_data,
  input wire logic [11:0] i_fetch_addr,
  output logic o_lit_word,
  output logic [2:0] o_lit_dest,
  output logic [15:0] o_lit_value,
  output logic [55:1] o_nano
);
  logic [74:0] mem [64];
  // empty entries read as a plain step word with no destinations
  initial begin
    for (int i = 0; i < 64; i++) begin
      mem[i] = 75'h0;
    end
  end
  // loading port, one entry per clock
  always @(posedge i_clk) begin
    if (i_wr) begin
      mem[i_wr_addr] <= i_wr_data;
    end
  end
  // asynchronous read, so the word stands as long as the address does
  assign {o_lit_word, o_lit_dest, o_lit_value, o_nano} = mem[i_fetch_addr[5:0]];
endmodule // nds_mpm_model

// >>> sim/testbench.sv
// testbench: runs a short microprogram through the sequencer and checks its registers
`timescale 1ns/10ps
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic wr = 1'b0;
  logic [5:0] wr_addr = 6'h00;
  logic [74:0] wr_data = 75'h0;
  logic [15:0] ext_bus = 16'h00a5;
  logic [3:0] dev_pend = 4'h6;
  logic [3:0] dev_sel = 4'h2;
  logic lit_word;
  logic [2:0] lit_dest;
  logic [15:0] lit_value;
  logic [55:1] nano;
  logic [11:0] fetch, mpc, step;
  logic ext3, stat_req;
  logic [2:0] adj;
  logic [3:0] req;
  logic [1:0] stat_dev;
  logic [7:0] memory_address_reg;
  logic [15:0] memory_info_reg, acc, breg;
  int mismatches = 0;
  int num_checks = 0;

  // 40 MHz clock
  always #12.5 clk = ~clk;

  nds_mpm_model nds_mpm_model_inst (.i_clk(clk), .i_wr(wr), .i_wr_addr(wr_addr),
    .i_wr_data(wr_data), .i_fetch_addr(fetch), .o_lit_word(lit_word),
    .o_lit_dest(lit_dest), .o_lit_value(lit_value), .o_nano(nano));

  nds_sequencer nds_sequencer_inst (.I_CLK(clk), .I_RST_N(rst_n), .I_CE(ce),
    .I_LIT_WORD(lit_word), .I_LIT_DEST(lit_dest), .I_LIT_VALUE(lit_value),
    .I_NANO_WORD(nano), .I_EXT_BUS(ext_bus), .I_DEV_PEND(dev_pend), .I_DEV_SEL(dev_sel),
    .O_FETCH_ADDR(fetch), .O_MICRO_PC(mpc), .O_STEP_VALUE(step), .O_EXT3(ext3),
    .O_COND_ADJ(adj), .O_MEM_DEV_REQ(req), .O_STATUS_REQ(stat_req),
    .O_STATUS_DEV(stat_dev), .O_MAR(memory_address_reg), .O_MIR(memory_info_reg), .O_ACC_ONE(acc), .O_B_REG(breg));

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // waits n edges, then lets their updates settle
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  function automatic logic [74:0] nw(logic [2:0] x, logic [2:0] y, logic [3:0] op,
      logic nc, logic [1:0] sh, logic [2:0] a, logic [3:0] b);
    nds_pkg::nds_nano_t n;
    n = nds_pkg::nds_nano_t'(55'h0);
    n.x_sel = x;
    n.y_sel = {4'h0, y};
    n.op = op;
    n.no_carry = nc;
    n.shift = sh;
    n.a_sel = a;
    n.b_sel = b;
    return {1'b0, 3'h0, 16'h0000, n};
  endfunction

  // control-only word: condition, sense set, successor pair, adjust
  function automatic logic [74:0] nc(logic [3:0] cond, logic [5:0] succ, logic [2:0] adj);
    nds_pkg::nds_nano_t n;
    n = nds_pkg::nds_nano_t'(55'h0);
    n.cond = cond;
    n.sense = 1'b1;
    n.succ = succ;
    n.adj = adj;
    return {1'b0, 3'h0, 16'h0000, n};
  endfunction

  task automatic put(logic [5:0] a, logic [74:0] d);
    @(posedge clk);
    wr <= 1'b1;
    wr_addr <= a;
    wr_data <= d;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset_and_load();
    nds_pkg::nds_nano_t n6;
    logic [74:0] w6;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    ce <= 1'b0;
    #1;
    chk("fetch in reset", 16'h0000, {4'h0, fetch});
    chk("acc in reset", 16'h0000, acc);
    put(6'h00, {1'b1, nds_pkg::LD_BOTH, 16'h0004, 55'h0});
    put(6'h01, nw(nds_pkg::X_LIT, 3'h7, nds_pkg::OP_PASSX, 1'b0, nds_pkg::SH_LEFT,
      nds_pkg::A_ONE, 4'h0));
    put(6'h02, nw(nds_pkg::X_A1, 3'h7, nds_pkg::OP_PASSX, 1'b0, nds_pkg::SH_CIRC, 3'h0,
      nds_pkg::B_BSW));
    put(6'h03, {1'b1, nds_pkg::LD_LIT, 16'h0080, 55'h0});
    put(6'h04, nw(nds_pkg::X_LIT, nds_pkg::Y_LIT, nds_pkg::OP_ADD, 1'b1, nds_pkg::SH_NONE,
      nds_pkg::A_ONE, 4'h0));
    put(6'h05, nw(nds_pkg::X_LIT, nds_pkg::Y_B, nds_pkg::OP_AAD, 1'b0, nds_pkg::SH_NONE,
      nds_pkg::A_ONE, 4'h0));
    w6 = nw(nds_pkg::X_A1, 3'h7, nds_pkg::OP_PASSX, 1'b0, nds_pkg::SH_NONE, 3'h0, 4'h0);
    n6 = w6[54:0];
    n6.sense = 1'b1;
    n6.ext_gate = 1'b1;
    n6.succ = {nds_pkg::SUCC_STEP, nds_pkg::SUCC_WAIT};
    n6.adj = nds_pkg::ADJ_LC1;
    n6.req = 4'h5;
    w6[54:0] = n6;
    put(6'h06, w6);
    @(posedge clk);
    wr <= 1'b0;
    ce <= 1'b1;
    #1;
    chk("fetch frozen", 16'h0000, {4'h0, fetch});
  endtask

  task automatic t_datapath();
    tick(1);
    chk("ext3 after literal", 16'h0001, {15'h0, ext3});
    chk("fetch step", 16'h0001, {4'h0, fetch});
    tick(1);
    chk("acc not yet", 16'h0000, acc);
    tick(1);
    chk("acc left shift", 16'h0040, acc);
    tick(1);
    chk("b held in ext3", 16'h0000, breg);
    tick(1);
    chk("b rotate", 16'h0004, breg);
    tick(1);
    chk("acc carry inhibit", 16'h0000, acc);
  endtask

  task automatic t_wait_ext();
    tick(1);
    chk("acc and-add", 16'h0080, acc);
    chk("fetch wait", 16'h0006, {4'h0, fetch});
    chk("mpc wait", 16'h0006, {4'h0, mpc});
    chk("request code", 16'h0005, {12'h0, req});
    chk("adjust code", 16'h0001, {13'h0, adj});
    tick(1);
    chk("fetch held", 16'h0006, {4'h0, fetch});
  endtask

  task automatic t_status_dev();
    chk("status device", 16'h0002, {14'h0, stat_dev});
    @(posedge clk);
    dev_sel <= 4'h6;
    tick(3);
    chk("no free device", 16'h0003, {14'h0, stat_dev});
  endtask

  // call, jump, flag test, status request and call-mark through a patched program
  task automatic t_branches();
    nds_pkg::nds_nano_t n7;
    logic [74:0] w7;
    w7 = nc(nds_pkg::COND_LC1, {nds_pkg::SUCC_STEP, nds_pkg::SUCC_CALL}, nds_pkg::ADJ_NONE);
    n7 = w7[54:0];
    n7.mir_ld = 1'b1;
    n7.mar_sel = nds_pkg::MAR_LIT;
    w7[54:0] = n7;
    @(posedge clk);
    dev_sel <= 4'h2;
    tick(2);
    put(6'h06, {1'b1, nds_pkg::LD_ALT, 16'h0010, 55'h0});
    ce <= 1'b0;
    put(6'h07, w7);
    put(6'h11, nc(nds_pkg::COND_TRUE, {nds_pkg::SUCC_STEP, nds_pkg::SUCC_JUMP},
      nds_pkg::ADJ_STATREQ));
    put(6'h08, nc(nds_pkg::COND_LC1, {nds_pkg::SUCC_SKIP, nds_pkg::SUCC_STEP},
      nds_pkg::ADJ_NONE));
    put(6'h0a, {1'b1, nds_pkg::LD_CALLMARK, 16'h0020, 55'h0});
    @(posedge clk);
    wr <= 1'b0;
    ce <= 1'b1;
    tick(2);
    chk("fetch call", 16'h0011, {4'h0, fetch});
    chk("mpc call", 16'h0011, {4'h0, mpc});
    tick(1);
    chk("mpc return point", 16'h0008, {4'h0, mpc});
    chk("fetch jump", 16'h0008, {4'h0, fetch});
    chk("mar from constant", 16'h0080, {8'h0, memory_address_reg});
    chk("mir from shifter", 16'h0084, memory_info_reg);
    chk("status request", 16'h0001, {15'h0, stat_req});
    tick(1);
    chk("flag cleared skip", 16'h000a, {4'h0, mpc});
    chk("status pulse ends", 16'h0000, {15'h0, stat_req});
    tick(1);
    chk("mpc call-mark", 16'h0021, {4'h0, mpc});
    chk("step call-mark", 16'h0021, {4'h0, step});
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence and watchdog
  initial begin
    t_reset_and_load();
    t_datapath();
    t_wait_ext();
    t_status_dev();
    t_branches();
    print_verdict();
  end

  initial begin
    repeat (500) @(posedge clk);
    mismatches++;
    print_verdict();
  end
endmodule // testbench
